// ---- core/sigio_regs.svh ----
// constants for the discrete start/stop interlock port
// assumes a 100 MHz clock and a 32-bit classic wishbone slave
`ifndef SIGIO_REGS_SVH
`define SIGIO_REGS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define SIGIO_CTRL_OFS 6'h00
`define SIGIO_STATUS_OFS 6'h04
`define SIGIO_MAP_OFS 6'h08
`define SIGIO_CMD_OFS 6'h0c

// ****************************************************************
// field positions
// ****************************************************************
`define SIGIO_CTRL_SRC_LSB 0
`define SIGIO_CTRL_ILK_EN_BIT 2
`define SIGIO_CMD_START_BIT 0
`define SIGIO_CMD_STOP_BIT 1
`define SIGIO_STS_STATE_LSB 0
`define SIGIO_STS_ILK_BIT 2
`define SIGIO_STS_ABORT_BIT 3
`define SIGIO_STS_PASS_BIT 4
`define SIGIO_STS_RELAY_LSB 8

// ****************************************************************
// reset values
// ****************************************************************
`define SIGIO_CTRL_RST 32'h0000_0000
`define SIGIO_MAP_RST 32'h0004_3210

// ****************************************************************
// timing
// ****************************************************************
`define SIGIO_CLK_HZ 100000000
`define SIGIO_MIN_PULSE_US 1000
`define SIGIO_MIN_PULSE_CYC ((`SIGIO_CLK_HZ / 1000000) * `SIGIO_MIN_PULSE_US)
`endif

// ---- core/sigio_pkg.sv ----
// types for the discrete start/stop interlock port
// assumes sigio_regs.svh for the numeric constants
package sigio_pkg;
    // operation control source
    typedef enum logic [1:0] {
        SRC_PANEL = 2'b00,
        SRC_DISCRETE = 2'b01,
        SRC_REMOTE = 2'b10,
        SRC_BUS = 2'b11
    } src_e;

    // test sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READY = 2'b01,
        ST_RUN = 2'b10
    } test_e;

    // status codes a relay may be mapped to
    typedef enum logic [2:0] {
        MAP_READY = 3'b000,
        MAP_RUN = 3'b001,
        MAP_PASS = 3'b010,
        MAP_FAIL = 3'b011,
        MAP_ABORT = 3'b100,
        MAP_ILK_OK = 3'b101,
        MAP_OFF = 3'b110,
        MAP_ON = 3'b111
    } map_e;

    // wishbone request
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [5:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_s;

    // wishbone answer
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_s;

    // debounced discrete inputs
    typedef struct packed {
        logic start_c;
        logic stop_c;
        logic loop_c;
    } dio_s;
endpackage : sigio_pkg

// ---- core/sigio_debounce.sv ----
// two-flop synchroniser plus stability filter for one closure input
// assumes a synchronous active-low reset copy
`timescale 1ns/1ps
`include "sigio_regs.svh"
module sigio_debounce #(
    parameter int unsigned CYCLES = `SIGIO_MIN_PULSE_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic raw_in,
    output logic level_q
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    logic s1_q;
    logic s2_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    wire differs = (s2_q != level_q);
    wire done = (cnt_q == CW'(CYCLES - 1));

    initial begin
        if (CYCLES < 2) $error("sigio_debounce: CYCLES must be at least 2");
    end

    // filter count: restarts whenever the input agrees with the output
    assign cnt_d = (!differs || done) ? '0 : cnt_q + CW'(1);

    // synchroniser and filter; level flips after CYCLES stable samples
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            cnt_q <= '0;
            level_q <= 1'b0;
        end else begin
            s1_q <= raw_in;
            s2_q <= s1_q;
            cnt_q <= cnt_d;
            if (differs && done) level_q <= s2_q;
        end
    end
endmodule : sigio_debounce

// ---- core/sigio_port.sv ----
// discrete start/stop interlock port with a wishbone register file
// assumes closures arrive active high after the input stage
// assumes a classic wishbone master, one request at a time
`timescale 1ns/1ps
`include "sigio_regs.svh"

// What this block does
// - discrete start/stop only when discrete source selected
// - stop closure of 1ms enters ready
// - start closure of 1ms from ready starts test
// - stop closure during test aborts it
// - panel stop key always aborts test
// - interlock enabled: start needs closed loop
// - interlock disabled: loop state ignored
// - five relay outputs report test status
// - relay meanings set by configuration
// - starts accepted only from selected source
module sigio_port #(
    parameter int unsigned PULSE_CYCLES = `SIGIO_MIN_PULSE_CYC,
    parameter int unsigned RELAYS = 5
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic start_closed,
    input wire logic stop_closed,
    input wire logic safety_loop_contact_a,
    input wire logic safety_loop_contact_b,
    input wire logic panel_start,
    input wire logic panel_stop,
    input wire logic remote_start,
    input wire logic remote_stop,
    input wire logic test_done,
    input wire logic test_fail,
    output logic test_run,
    output logic [RELAYS-1:0] relay_q
);
    // ****************************************************************
    // reset release
    // ****************************************************************
    logic rst_a_q;
    logic rst_n;

    initial begin
        if (RELAYS != 5) $error("sigio_port: RELAYS must be 5");
    end

    // two-flop release of the asynchronous reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_a_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_a_q <= 1'b1;
            rst_n <= rst_a_q;
        end
    end

    // ****************************************************************
    // input conditioning
    // ****************************************************************
    sigio_pkg::dio_s dio;
    wire loop_raw = safety_loop_contact_a & safety_loop_contact_b;

    // each closure synchronised and held stable 1ms before use
    sigio_debounce #(.CYCLES(PULSE_CYCLES)) u_start (.clk(clk), .rst_n(rst_n), .raw_in(start_closed),
        .level_q(dio.start_c));
    sigio_debounce #(.CYCLES(PULSE_CYCLES)) u_stop (.clk(clk), .rst_n(rst_n), .raw_in(stop_closed),
        .level_q(dio.stop_c));
    sigio_debounce #(.CYCLES(PULSE_CYCLES)) u_loop (.clk(clk), .rst_n(rst_n), .raw_in(loop_raw),
        .level_q(dio.loop_c));

    // rising edges of the filtered closures
    logic start_prev_q;
    logic stop_prev_q;
    wire start_rise = dio.start_c & ~start_prev_q;
    wire stop_rise = dio.stop_c & ~stop_prev_q;

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [31:0] ctrl_q;
    logic [31:0] map_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic cmd_start;
    logic cmd_stop;
    sigio_pkg::src_e src;
    logic ilk_en;

    assign src = sigio_pkg::src_e'(ctrl_q[`SIGIO_CTRL_SRC_LSB +: 2]);
    assign ilk_en = ctrl_q[`SIGIO_CTRL_ILK_EN_BIT];

    // bus decode
    wire wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
    wire wb_wr = wb_req & wb_we_i;
    wire hit_ctrl = (wb_adr_i == `SIGIO_CTRL_OFS);
    wire hit_sts = (wb_adr_i == `SIGIO_STATUS_OFS);
    wire hit_map = (wb_adr_i == `SIGIO_MAP_OFS);
    wire hit_cmd = (wb_adr_i == `SIGIO_CMD_OFS);
    assign cmd_start = wb_wr & hit_cmd & wb_sel_i[0] & wb_dat_i[`SIGIO_CMD_START_BIT];
    assign cmd_stop = wb_wr & hit_cmd & wb_sel_i[0] & wb_dat_i[`SIGIO_CMD_STOP_BIT];

    // byte-lane merge for writable registers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction : merge

    // ****************************************************************
    // test sequencer
    // ****************************************************************
    sigio_pkg::test_e st_q;
    sigio_pkg::test_e st_d;
    logic abort_q;
    logic pass_q;
    logic fail_q;
    logic any_start;
    logic any_stop;
    logic loop_ok;

    // select the single active start source; panel and bus stops act from any source
    assign any_start = (src == sigio_pkg::SRC_DISCRETE) ? start_rise :
                       (src == sigio_pkg::SRC_PANEL) ? panel_start :
                       (src == sigio_pkg::SRC_REMOTE) ? remote_start : cmd_start;
    assign any_stop = panel_stop
                    | ((src == sigio_pkg::SRC_DISCRETE) & stop_rise)
                    | ((src == sigio_pkg::SRC_REMOTE) & remote_stop)
                    | cmd_stop;
    assign loop_ok = ~ilk_en | dio.loop_c;

    // next state
    always_comb begin
        st_d = st_q;
        case (st_q)
            sigio_pkg::ST_IDLE: begin
                if (any_stop) st_d = sigio_pkg::ST_READY;
            end
            sigio_pkg::ST_READY: begin
                if (any_start && !any_stop && loop_ok) st_d = sigio_pkg::ST_RUN;
            end
            sigio_pkg::ST_RUN: begin
                if (any_stop || !loop_ok) st_d = sigio_pkg::ST_READY;
                else if (test_done) st_d = sigio_pkg::ST_READY;
            end
            default: st_d = sigio_pkg::ST_IDLE;
        endcase
    end

    wire aborting = (st_q == sigio_pkg::ST_RUN) && (any_stop || !loop_ok);
    wire finishing = (st_q == sigio_pkg::ST_RUN) && !aborting && test_done;
    wire starting = (st_d == sigio_pkg::ST_RUN) && (st_q != sigio_pkg::ST_RUN);

    // state and result flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= sigio_pkg::ST_IDLE;
            abort_q <= 1'b0;
            pass_q <= 1'b0;
            fail_q <= 1'b0;
            start_prev_q <= 1'b0;
            stop_prev_q <= 1'b0;
        end else begin
            st_q <= st_d;
            start_prev_q <= dio.start_c;
            stop_prev_q <= dio.stop_c;
            abort_q <= aborting | (abort_q & ~starting);
            pass_q <= (finishing & ~test_fail) | (pass_q & ~starting);
            fail_q <= (finishing & test_fail) | (fail_q & ~starting);
        end
    end

    assign test_run = (st_q == sigio_pkg::ST_RUN);

    // ****************************************************************
    // relay outputs
    // ****************************************************************
    // status code to relay level
    function automatic logic relay_val(input logic [2:0] code, input logic [5:0] stv);
        return stv[code[2:0] > 3'd5 ? 3'd0 : code] & (code != 3'd6) | (code == 3'd7);
    endfunction : relay_val

    wire [5:0] stv = {dio.loop_c, abort_q, fail_q, pass_q, test_run, st_q == sigio_pkg::ST_READY};

    // each relay follows the status chosen in the map register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            relay_q <= '0;
        end else begin
            for (int i = 0; i < RELAYS; i++) begin
                relay_q[i] <= relay_val(map_q[i*4 +: 3], stv);
            end
        end
    end

    // ****************************************************************
    // wishbone slave
    // ****************************************************************
    wire [31:0] sts_word = {16'h0000, 3'b000, relay_q, 3'b000, pass_q, abort_q, dio.loop_c, st_q};
    wire [31:0] rd_mux = hit_ctrl ? ctrl_q : hit_sts ? sts_word : hit_map ? map_q : 32'h0000_0000;

    // single-wait answer; unmapped reads return zero, writes dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `SIGIO_CTRL_RST;
            map_q <= `SIGIO_MAP_RST;
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= wb_req;
            if (wb_req) rdat_q <= rd_mux;
            if (wb_wr && hit_ctrl) ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_0007;
            if (wb_wr && hit_map) ctrl_q <= ctrl_q;
            if (wb_wr && hit_map) map_q <= merge(map_q, wb_dat_i, wb_sel_i) & 32'h000f_ffff;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_src_gate;
        @(posedge clk) disable iff (!rst_n)
        (src != sigio_pkg::SRC_DISCRETE && !panel_stop && !cmd_stop && !(src == sigio_pkg::SRC_REMOTE && remote_stop)
         && st_q == sigio_pkg::ST_IDLE) |=> st_q == sigio_pkg::ST_IDLE;
    endproperty
    a_src_gate: assert property (p_src_gate) else $error("ready entered without a stop");

    property p_ready;
        @(posedge clk) disable iff (!rst_n)
        (st_q == sigio_pkg::ST_IDLE && src == sigio_pkg::SRC_DISCRETE && stop_rise) |=> st_q == sigio_pkg::ST_READY;
    endproperty
    a_ready: assert property (p_ready) else $error("stop closure did not give ready");

    property p_start;
        @(posedge clk) disable iff (!rst_n)
        $rose(test_run) |-> $past(st_q) == sigio_pkg::ST_READY && $past(loop_ok);
    endproperty
    a_start: assert property (p_start) else $error("test started from wrong state");

    property p_stop_abort;
        @(posedge clk) disable iff (!rst_n)
        (test_run && src == sigio_pkg::SRC_DISCRETE && stop_rise) |=> !test_run && abort_q;
    endproperty
    a_stop_abort: assert property (p_stop_abort) else $error("stop closure did not abort");

    property p_panel_stop;
        @(posedge clk) disable iff (!rst_n)
        (test_run && panel_stop) |=> !test_run;
    endproperty
    a_panel_stop: assert property (p_panel_stop) else $error("panel stop ignored");

    property p_ilk_start;
        @(posedge clk) disable iff (!rst_n)
        (ilk_en && !dio.loop_c && !test_run) |=> !test_run;
    endproperty
    a_ilk_start: assert property (p_ilk_start) else $error("start with open loop");

    property p_ilk_open;
        @(posedge clk) disable iff (!rst_n)
        (ilk_en && !dio.loop_c && test_run) |=> !test_run;
    endproperty
    a_ilk_open: assert property (p_ilk_open) else $error("open loop did not interrupt");

    property p_relay;
        @(posedge clk) disable iff (!rst_n)
        (map_q[2:0] == 3'b001) ##1 (map_q[2:0] == 3'b001) |-> relay_q[0] == $past(test_run);
    endproperty
    a_relay: assert property (p_relay) else $error("relay does not follow mapped status");

    property p_wb_ack;
        @(posedge clk) disable iff (!rst_n)
        (wb_cyc_i && wb_stb_i && !ack_q) |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("bus answer not one cycle");

    property p_ilk_off;
        @(posedge clk) disable iff (!rst_n)
        (!ilk_en && test_run && !any_stop && !test_done) |=> test_run;
    endproperty
    a_ilk_off: assert property (p_ilk_off) else $error("run ended with interlock off");

    property p_done;
        @(posedge clk) disable iff (!rst_n)
        (test_run && test_done && !aborting) |=> !test_run && (pass_q != fail_q);
    endproperty
    a_done: assert property (p_done) else $error("finished test gave no single result");

    c_run: cover property (@(posedge clk) disable iff (!rst_n) $rose(test_run));
    c_abort: cover property (@(posedge clk) disable iff (!rst_n) $rose(abort_q));
    c_pass: cover property (@(posedge clk) disable iff (!rst_n) $rose(pass_q));
    c_fail: cover property (@(posedge clk) disable iff (!rst_n) $rose(fail_q));
endmodule : sigio_port

// ---- tb/sigio_far_side.sv ----
// far-side model: start/stop contacts and the interlock key
// assumes the bench calls its tasks, always just after a rising edge
`timescale 1ns/1ps
module sigio_far_side (
    input wire logic clk,
    output logic start_closed,
    output logic stop_closed,
    output logic safety_loop_contact_a,
    output logic safety_loop_contact_b
);
    // ****************************************************************
    // contacts open, key out at time zero
    // ****************************************************************
    initial begin
        start_closed = 1'b0;
        stop_closed = 1'b0;
        safety_loop_contact_a = 1'b0;
        safety_loop_contact_b = 1'b0;
    end

    // close one contact for hold cycles, open it, let the filter settle
    task automatic close(input logic go, input int hold);
        @(posedge clk);
        if (go) begin
            start_closed <= 1'b1;
        end else begin
            stop_closed <= 1'b1;
        end
        repeat (hold) @(posedge clk);
        start_closed <= 1'b0;
        stop_closed <= 1'b0;
        repeat (16) @(posedge clk);
    endtask : close

    // key pins, each side separately so a half-made loop can be shown
    task automatic key(input logic a, input logic b);
        @(posedge clk);
        safety_loop_contact_a <= a;
        safety_loop_contact_b <= b;
        repeat (16) @(posedge clk);
    endtask : key
endmodule : sigio_far_side

// ---- tb/test_sigio_port.sv ----
// self-checking bench for the discrete start/stop interlock port
// assumes sigio_pkg compiled first and sigio_regs.svh on the include path
`timescale 1ns/1ps
`include "sigio_regs.svh"
module test_sigio_port;
    localparam int unsigned PULSE = 8;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    sigio_pkg::wb_req_s req = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic start_closed, stop_closed, loop_a, loop_b;
    logic [4:0] kick = '0; // panel start/stop, remote start/stop, done
    logic test_fail = 1'b0;
    logic test_run;
    logic [4:0] relay_q;
    logic [31:0] rd_q;
    logic [31:0] map_q = `SIGIO_MAP_RST;
    logic [7:0] seed = 8'h53;
    sigio_pkg::test_e st = sigio_pkg::ST_IDLE;
    logic ps = 1'b0, fl = 1'b0, ab = 1'b0, lp = 1'b0;
    int fail_count = 0;
    int total_checks = 0;

    always #5 clk = ~clk;

    sigio_port #(.PULSE_CYCLES(PULSE), .RELAYS(5)) u_sigio_port (.clk(clk), .resetn(resetn),
        .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel),
        .wb_dat_i(req.dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .start_closed(start_closed),
        .stop_closed(stop_closed), .safety_loop_contact_a(loop_a), .safety_loop_contact_b(loop_b),
        .panel_start(kick[0]), .panel_stop(kick[1]), .remote_start(kick[2]), .remote_stop(kick[3]),
        .test_done(kick[4]), .test_fail(test_fail), .test_run(test_run), .relay_q(relay_q));
    sigio_far_side u_sigio_far_side (.clk(clk), .start_closed(start_closed), .stop_closed(stop_closed),
        .safety_loop_contact_a(loop_a), .safety_loop_contact_b(loop_b));

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr
    // random closure length, always beyond the filter
    function automatic int hold();
        seed = lfsr(seed);
        return 12 + seed[3:0];
    endfunction : hold
    // expected relay level for one status code
    function automatic logic rel(input logic [2:0] c);
        logic [7:0] v;
        v = {1'b1, 1'b0, lp, ab, fl, ps, st == sigio_pkg::ST_RUN, st == sigio_pkg::ST_READY};
        return v[c];
    endfunction : rel
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // classic single wishbone cycle, waits for ack
    task automatic bus(input logic we, input logic [5:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1);
        chk(n, 32'd2); // answer one cycle after the taken edge
        rd_q = wb_dat_o;
        req <= '0;
    endtask : bus
    task automatic pulse(input int b);
        @(posedge clk);
        kick <= 5'h01 << b;
        @(posedge clk);
        kick <= '0;
        repeat (4) @(posedge clk);
    endtask : pulse
    // status word, relay pins and run flag against the bench's model
    task automatic look();
        logic [4:0] r;
        for (int k = 0; k < 5; k++) r[k] = rel(map_q[4*k +: 3]);
        bus(1'b0, `SIGIO_STATUS_OFS, 32'h0);
        chk({27'h0, rd_q[4:0]}, {27'h0, ps, ab, lp, st});
        chk({27'h0, rd_q[12:8]}, {27'h0, r});
        chk({27'h0, relay_q}, {27'h0, r});
        chk({31'h0, test_run}, {31'h0, st == sigio_pkg::ST_RUN});
    endtask : look
    task automatic start_ok();
        u_sigio_far_side.close(1'b1, hold());
        st = sigio_pkg::ST_RUN;
        {ps, fl, ab} = 3'b000;
    endtask : start_ok
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        #200000;
        fail_count++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, `SIGIO_CTRL_OFS, 32'h0);
        chk(rd_q, `SIGIO_CTRL_RST);
        bus(1'b0, `SIGIO_MAP_OFS, 32'h0);
        chk(rd_q, `SIGIO_MAP_RST);
        bus(1'b1, 6'h10, 32'hffff_ffff);
        bus(1'b0, 6'h10, 32'h0);
        chk(rd_q, 32'h0);
        u_sigio_far_side.close(1'b0, hold());
        u_sigio_far_side.close(1'b1, hold());
        look();
        bus(1'b1, `SIGIO_CTRL_OFS, 32'h1);
        u_sigio_far_side.close(1'b0, 4);
        look();
        u_sigio_far_side.close(1'b0, hold());
        st = sigio_pkg::ST_READY;
        look();
        pulse(0);
        pulse(2);
        bus(1'b1, `SIGIO_CMD_OFS, 32'h1);
        look();
        start_ok();
        look();
        u_sigio_far_side.close(1'b0, hold());
        st = sigio_pkg::ST_READY;
        ab = 1'b1;
        look();
        start_ok();
        pulse(1);
        st = sigio_pkg::ST_READY;
        ab = 1'b1;
        look();
        for (int i = 0; i < 2; i++) begin
            start_ok();
            seed = lfsr(seed);
            test_fail <= seed[0] ^ i[0];
            fl = seed[0] ^ i[0];
            pulse(4);
            ps = ~fl;
            st = sigio_pkg::ST_READY;
            look();
        end
        bus(1'b1, `SIGIO_CTRL_OFS, 32'h5);
        u_sigio_far_side.key(1'b1, 1'b0);
        u_sigio_far_side.close(1'b1, hold());
        look();
        u_sigio_far_side.key(1'b1, 1'b1);
        lp = 1'b1;
        start_ok();
        look();
        for (int c = 1; c < 8; c++) begin
            map_q = {12'h0, {5{c[3:0]}}};
            bus(1'b1, `SIGIO_MAP_OFS, map_q);
            look();
        end
        map_q = `SIGIO_MAP_RST;
        bus(1'b1, `SIGIO_MAP_OFS, map_q);
        u_sigio_far_side.key(1'b0, 1'b1);
        lp = 1'b0;
        st = sigio_pkg::ST_READY;
        ab = 1'b1;
        look();
        bus(1'b1, `SIGIO_CTRL_OFS, 32'h1);
        start_ok();
        u_sigio_far_side.key(1'b0, 1'b0);
        look();
        // mid-run reset: outputs drop, control register returns to its reset value
        @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk);
        chk({31'h0, test_run}, 32'h0);
        chk({27'h0, relay_q}, 32'h0);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        st = sigio_pkg::ST_IDLE;
        {ps, fl, ab} = 3'b000;
        bus(1'b0, `SIGIO_CTRL_OFS, 32'h0);
        chk(rd_q, `SIGIO_CTRL_RST);
        // bus command source, then the remote source
        bus(1'b1, `SIGIO_CTRL_OFS, 32'h3);
        bus(1'b1, `SIGIO_CMD_OFS, 32'h2);
        st = sigio_pkg::ST_READY;
        look();
        bus(1'b1, `SIGIO_CMD_OFS, 32'h1);
        st = sigio_pkg::ST_RUN;
        look();
        bus(1'b1, `SIGIO_CTRL_OFS, 32'h2);
        pulse(3);
        pulse(0);
        st = sigio_pkg::ST_READY;
        ab = 1'b1;
        look();
        pulse(2);
        st = sigio_pkg::ST_RUN;
        ab = 1'b0;
        look();
        conclude();
    end
endmodule : test_sigio_port
